/* File: core/lfwk_mode_ctrl.sv */
// Mode controller of a three-channel low-frequency wakeup receiver
`default_nettype none
module lfwk_mode_ctrl #(
  parameter int unsigned SLOT_CYC  = lfwk_pkg::SLOT_CYCLES,
  parameter int unsigned PULSE_CYC = lfwk_pkg::WAKE_PULSE_CYC,
  parameter int unsigned RTC_PER_S = lfwk_pkg::RTC_TICKS_PER_S
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Serial register port
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe,
  // Real-time clock and front end
  input  wire logic       rtc_clk,
  input  wire logic [2:0] carrier_det,
  input  wire logic       envelope,
  input  wire logic [4:0] strength_ch_one,
  input  wire logic [4:0] strength_ch_two,
  input  wire logic [4:0] strength_ch_three,
  // Front-end control
  output logic [2:0]      amp_on,
  output logic [1:0]      demod_sel,
  output logic            correlator_on,
  output logic            rtc_run,
  // Host pins
  output logic            wake_out,
  output logic            demod_bitstream_pin,
  output logic            recovered_bitclock_pin
);
  // ==========================================================
  // Synchronisers: first stage feeds only the second
  logic [7:0] sync1, sync2;
  logic [2:0] prev;
  always_ff @(posedge mclk) begin
    sync1 <= {carrier_det, envelope, rtc_clk, spi_sdi, spi_cs_n, spi_sclk};
    sync2 <= sync1;
    prev  <= {sync2[4], sync2[3], sync2[0]};
  end
  logic sclk_rise, sclk_fall, rtc_tick, env_edge, any_carrier;
  assign sclk_rise   = sync2[0] & ~prev[0];
  assign sclk_fall   = ~sync2[0] & prev[0];
  assign rtc_tick    = sync2[3] & ~prev[1];
  assign env_edge    = sync2[4] ^ prev[2];
  assign any_carrier = |sync2[7:5];

  // ==========================================================
  // Registers
  logic [lfwk_pkg::NUM_CFG-1:0][7:0] cfg;
  logic [2:0][4:0] strength;
  logic [7:0]      false_cnt;
  logic [2:0]      chan_en;
  logic            power_down_bit, scan_en, on_off, corr_en, biphase_en, double_en;
  assign chan_en    = {cfg[0][lfwk_pkg::BIT_EN_THREE], cfg[0][lfwk_pkg::BIT_EN_TWO],
                       cfg[0][lfwk_pkg::BIT_EN_ONE]};
  assign power_down_bit        = cfg[0][lfwk_pkg::BIT_PWD];
  assign scan_en    = cfg[0][lfwk_pkg::BIT_SCAN];
  assign on_off     = cfg[0][lfwk_pkg::BIT_ON_OFF];
  assign corr_en    = cfg[1][lfwk_pkg::BIT_CORR];
  assign biphase_en = cfg[1][lfwk_pkg::BIT_BIPHASE];
  assign double_en  = cfg[1][lfwk_pkg::BIT_DOUBLE];

  // ==========================================================
  // Serial slave: 2-bit mode, 6-bit address, 8-bit data, MSB first
  lfwk_pkg::lfwk_frame_s frame;
  logic [4:0] bit_cnt;
  logic [7:0] sdo_sh;
  logic [7:0] rd_data;
  logic       clear_cmd, rd_mode;
  // Read address still sits in the low byte when the reply is loaded
  always_comb begin
    rd_data = 8'h00;
    if (frame.data[5:0] < lfwk_pkg::REG_RESERVED)
      rd_data = cfg[frame.data[3:0]];
    else if (frame.data[5:0] == lfwk_pkg::REG_STR_ONE)
      rd_data = {3'h0, strength[0]};
    else if (frame.data[5:0] == lfwk_pkg::REG_STR_THREE)
      rd_data = {3'h0, strength[2]};
    else if (frame.data[5:0] == lfwk_pkg::REG_STR_TWO)
      rd_data = {3'h0, strength[1]};
    else if (frame.data[5:0] == lfwk_pkg::REG_FALSE_CNT)
      rd_data = false_cnt;
  end
  always_ff @(posedge mclk) begin
    if (reset || sync2[1]) begin
      bit_cnt <= 5'h00;
      frame   <= '0;
      rd_mode <= 1'b0;
    end else if (sclk_rise && bit_cnt != 5'h10) begin
      bit_cnt <= bit_cnt + 5'h01;
      frame   <= {frame[14:0], sync2[2]};
      if (bit_cnt == 5'h08)
        rd_mode <= frame.data[7:6] == lfwk_pkg::SPI_READ;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset || sync2[1])
      sdo_sh <= 8'h00;
    else if (bit_cnt == 5'h08 && sclk_fall && frame.data[7:6] == lfwk_pkg::SPI_READ)
      sdo_sh <= rd_data;
    else if (bit_cnt > 5'h08 && sclk_fall)
      sdo_sh <= {sdo_sh[6:0], 1'b0};
  end
  // Address sits in the low bits until its last bit arrives, so the command is decoded then
  assign clear_cmd = sclk_rise && bit_cnt == 5'h07 && frame.data[6:5] == lfwk_pkg::SPI_CMD
                     && {frame.data[4:0], sync2[2]} == lfwk_pkg::CMD_CLEAR_WAKE;
  always_ff @(posedge mclk) begin
    if (reset) begin
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo    <= sdo_sh[7];
      // Mode bits leave the low byte as data arrives, so a held flag carries it on
      spi_sdo_oe <= ~sync2[1] && (bit_cnt == 5'h08 ? frame.data[7:6] == lfwk_pkg::SPI_READ
                                                   : bit_cnt > 5'h08 && rd_mode);
    end
  end
  always_ff @(posedge mclk) begin
    if (reset)
      cfg <= lfwk_pkg::CFG_RESET;
    else if (sclk_rise && bit_cnt == 5'h0F && frame[12:7] < lfwk_pkg::REG_RESERVED
             && frame[14:13] == lfwk_pkg::SPI_WRITE)
      cfg[frame[12:7]] <= {frame.data[6:0], sync2[2]};
  end

  // ==========================================================
  // Millisecond base and listening timing
  logic [15:0] ms_cnt;
  logic        ms_tick;
  assign ms_tick = ms_cnt == 16'(SLOT_CYC - 1);
  always_ff @(posedge mclk) begin
    if (reset || power_down_bit || ms_tick)
      ms_cnt <= 16'h0000;
    else
      ms_cnt <= ms_cnt + 16'h0001;
  end
  lfwk_pkg::lfwk_state_e state;
  logic [1:0] scan_ch;
  logic [3:0] off_ms;
  logic       in_off;
  // Next channel in the order one, three, two, skipping disabled ones
  function automatic logic [1:0] next_scan(input logic [1:0] cur, input logic [2:0] en);
    logic [1:0] c;
    c = cur;
    for (int i = 0; i < 3; i++) begin
      c = (c == 2'd0) ? 2'd2 : (c == 2'd2) ? 2'd1 : 2'd0;
      if (en[c]) return c;
    end
    return cur;
  endfunction
  always_ff @(posedge mclk) begin
    if (reset || state != lfwk_pkg::ST_LISTEN)
      scan_ch <= 2'd0;
    else if (ms_tick || !chan_en[scan_ch])
      scan_ch <= next_scan(scan_ch, chan_en);
  end
  // On slot of one millisecond, off for 1, 2, 4 or 8
  always_ff @(posedge mclk) begin
    if (reset || state != lfwk_pkg::ST_LISTEN || !on_off) begin
      in_off <= 1'b0;
      off_ms <= 4'h0;
    end else if (ms_tick && !in_off) begin
      in_off <= 1'b1;
      off_ms <= 4'(4'h1 << cfg[4][lfwk_pkg::POS_T_OFF +: 2]) - 4'h1;
    end else if (ms_tick) begin
      in_off <= off_ms != 4'h0;
      off_ms <= off_ms - 4'h1;
    end
  end
  always_comb begin
    amp_on = 3'h0;
    if (state == lfwk_pkg::ST_LISTEN && scan_en)
      amp_on = 3'(chan_en & (3'h1 << scan_ch));
    else if (state == lfwk_pkg::ST_LISTEN)
      amp_on = in_off ? 3'h0 : chan_en;
    else if (state != lfwk_pkg::ST_PWD)
      amp_on = chan_en;
  end
  assign rtc_run       = state != lfwk_pkg::ST_PWD;
  assign correlator_on = state == lfwk_pkg::ST_PREAMBLE || state == lfwk_pkg::ST_PATTERN;

  // ==========================================================
  // Envelope edge timing and biphase decoding
  logic [6:0]  itv;
  logic [4:0]  hb;
  logic        short_itv, long_itv;
  logic [3:0]  pre_cnt;
  logic        at_mid;
  logic [31:0] bits;
  logic [5:0]  nbits;
  logic        match, fail, rec_clk;
  assign hb        = cfg[7][4:0];
  assign short_itv = {itv, 1'b0} < {2'b00, hb, 1'b0} + {3'b000, hb};
  assign long_itv  = !short_itv && {itv, 1'b0} < {1'b0, hb, 2'b00} + {3'b000, hb};
  always_ff @(posedge mclk) begin
    if (reset || env_edge)
      itv <= 7'h00;
    else if (rtc_tick && itv != 7'h7F)
      itv <= itv + 7'h01;
  end
  // Preamble is a run of half-bit spaced edges
  always_ff @(posedge mclk) begin
    if (reset || state != lfwk_pkg::ST_PREAMBLE)
      pre_cnt <= 4'h0;
    else if (env_edge)
      pre_cnt <= short_itv ? pre_cnt + 4'h1 : 4'h0;
  end
  // Clock recovery: long gaps and every second short gap mark mid-bit
  always_ff @(posedge mclk) begin
    if (reset || state == lfwk_pkg::ST_PREAMBLE) begin
      at_mid <= 1'b1;
      bits   <= 32'h0;
      nbits  <= 6'h00;
    end else if (env_edge && (state == lfwk_pkg::ST_PATTERN ||
                              state == lfwk_pkg::ST_RECEIVE)) begin
      at_mid <= long_itv | ~at_mid;
      if (long_itv || !at_mid) begin
        bits  <= {bits[30:0], sync2[4]};
        nbits <= nbits + 6'h01;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset)
      rec_clk <= 1'b0;
    else
      rec_clk <= state == lfwk_pkg::ST_RECEIVE && at_mid;
  end
  assign match = bits[15:0] == {cfg[6], cfg[5]} && nbits >= (double_en ? 6'd32 : 6'd16)
                 && (!double_en || bits[31:16] == {cfg[6], cfg[5]});
  assign fail  = nbits == 6'(lfwk_pkg::PATTERN_SLACK + (double_en ? 32 : 16))
                 || (env_edge && !short_itv && !long_itv) || !any_carrier;

  // ==========================================================
  // Mode sequence
  logic [15:0] eval_cnt;
  logic [8:0]  tout_ms;
  logic [2:0]  tout_sel;
  logic        pat_wake;
  assign tout_sel = cfg[7][lfwk_pkg::POS_T_OUT +: 3];
  always_ff @(posedge mclk) begin
    if (reset || state != lfwk_pkg::ST_EVAL)
      eval_cnt <= 16'h0000;
    else
      eval_cnt <= eval_cnt + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (reset || state != lfwk_pkg::ST_RECEIVE)
      tout_ms <= 9'h000;
    else if (ms_tick)
      tout_ms <= tout_ms + 9'h001;
  end
  always_ff @(posedge mclk) begin
    if (reset || power_down_bit) begin
      state    <= lfwk_pkg::ST_PWD;
      pat_wake <= 1'b0;
    end else begin
      unique case (state)
        lfwk_pkg::ST_PWD:
          state <= lfwk_pkg::ST_LISTEN;
        // Carrier on a channel whose amplifier is on stops rotation, all enabled channels on
        lfwk_pkg::ST_LISTEN:
          if (|(sync2[7:5] & amp_on))
            state <= lfwk_pkg::ST_EVAL;
        lfwk_pkg::ST_EVAL:
          if (eval_cnt == 16'(SLOT_CYC - 1)) begin
            state    <= corr_en ? lfwk_pkg::ST_PREAMBLE : lfwk_pkg::ST_RECEIVE;
            pat_wake <= !corr_en;
          end
        lfwk_pkg::ST_PREAMBLE:
          if (!any_carrier)
            state <= lfwk_pkg::ST_LISTEN;
          else if (pre_cnt == 4'(lfwk_pkg::PREAMBLE_EDGES))
            state <= lfwk_pkg::ST_PATTERN;
        // Match wakes the host, mismatch drops silently
        lfwk_pkg::ST_PATTERN:
          if (match) begin
            state    <= lfwk_pkg::ST_RECEIVE;
            pat_wake <= 1'b1;
          end else if (fail)
            state <= lfwk_pkg::ST_LISTEN;
        lfwk_pkg::ST_RECEIVE:
          if (clear_cmd || (tout_sel != 3'h0 &&
              tout_ms == 9'(tout_sel) * 9'(lfwk_pkg::TOUT_STEP_MS))) begin
            state    <= lfwk_pkg::ST_LISTEN;
            pat_wake <= 1'b0;
          end
        default: begin
          state    <= lfwk_pkg::ST_LISTEN;
          pat_wake <= 1'b0;
        end
      endcase
    end
  end
  // Latch strengths at end of evaluation, pick the strongest
  always_ff @(posedge mclk) begin
    if (reset) begin
      strength  <= '0;
      demod_sel <= 2'd0;
    end else if (state == lfwk_pkg::ST_EVAL && eval_cnt == 16'(SLOT_CYC - 1)) begin
      strength  <= {chan_en[2] ? strength_ch_three : 5'h00,
                    chan_en[1] ? strength_ch_two : 5'h00,
                    chan_en[0] ? strength_ch_one : 5'h00};
      demod_sel <= 2'd0;
      if (chan_en[1] && strength_ch_two > strength_ch_one)
        demod_sel <= 2'd1;
      if (chan_en[2] && strength_ch_three > strength_ch_one &&
          strength_ch_three > strength_ch_two)
        demod_sel <= 2'd2;
    end
  end
  // False wakeup count on pattern failure
  always_ff @(posedge mclk) begin
    if (reset)
      false_cnt <= 8'h00;
    else if (state == lfwk_pkg::ST_PATTERN && !match && fail)
      false_cnt <= false_cnt + 8'h01;
  end

  // ==========================================================
  // Artificial wakeup; seconds are counted from RTC ticks, so the tick rate is a parameter
  logic [15:0] sub_s;
  logic [12:0] secs;
  logic [12:0] pulse_cnt;
  logic [12:0] window;
  assign window = lfwk_pkg::AUTO_SECONDS[cfg[8][lfwk_pkg::POS_T_AUTO +: 3]];
  // Window counted in RTC seconds, any activity restarts it
  always_ff @(posedge mclk) begin
    if (reset || state != lfwk_pkg::ST_LISTEN || any_carrier || window == 13'h0000
        || secs == window) begin
      sub_s <= 16'h0000;
      secs  <= 13'h0000;
    end else if (rtc_tick && sub_s == 16'(RTC_PER_S - 1)) begin
      sub_s <= 16'h0000;
      secs  <= secs + 13'h0001;
    end else if (rtc_tick)
      sub_s <= sub_s + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (reset || power_down_bit)
      pulse_cnt <= 13'h0000;
    else if (window != 13'h0000 && secs == window)
      pulse_cnt <= 13'(PULSE_CYC);
    else if (pulse_cnt != 13'h0000)
      pulse_cnt <= pulse_cnt - 13'h0001;
  end
  // Data and recovered clock on the host pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_out               <= 1'b0;
      demod_bitstream_pin    <= 1'b0;
      recovered_bitclock_pin <= 1'b0;
    end else begin
      wake_out               <= pat_wake || pulse_cnt != 13'h0000;
      demod_bitstream_pin    <= state == lfwk_pkg::ST_RECEIVE && sync2[4];
      recovered_bitclock_pin <= biphase_en && rec_clk;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_pwd_all_off: assert property (power_down_bit |=> amp_on == 3'h0 && !rtc_run)
    else $error("power-down left activity");
  a_scan_one_chan: assert property (state == lfwk_pkg::ST_LISTEN && scan_en
    |-> $onehot0(amp_on)) else $error("more than one channel while scanning");
  a_std_all_on: assert property (state == lfwk_pkg::ST_LISTEN && !scan_en && !on_off
    |-> amp_on == chan_en) else $error("standard listening not all channels");
  a_eval_all_on: assert property (state == lfwk_pkg::ST_EVAL |-> amp_on == chan_en)
    else $error("evaluation without all channels");
  a_match_wake: assert property (state == lfwk_pkg::ST_PATTERN && match && !power_down_bit
    |=> state == lfwk_pkg::ST_RECEIVE ##1 wake_out) else $error("match did not wake");
  a_mismatch_quiet: assert property (state == lfwk_pkg::ST_PATTERN && !match && fail
    |=> state == lfwk_pkg::ST_LISTEN && false_cnt == $past(false_cnt) + 8'h01 ##1 !pat_wake)
    else $error("mismatch handling wrong");
  a_clear_listen: assert property (state == lfwk_pkg::ST_RECEIVE && clear_cmd && !power_down_bit
    |=> state == lfwk_pkg::ST_LISTEN && !pat_wake) else $error("clear-wakeup ignored");
  a_bypass_wake: assert property (state == lfwk_pkg::ST_EVAL && !corr_en
    && eval_cnt == 16'(SLOT_CYC - 1) && !power_down_bit |=> state == lfwk_pkg::ST_RECEIVE ##1 wake_out)
    else $error("bypass did not wake");
  a_pulse_len: assert property ($rose(pulse_cnt != 13'h0000) && !pat_wake
    |=> wake_out [*8]) else $error("artificial pulse too short");
  c_scan_hit: cover property (state == lfwk_pkg::ST_LISTEN && scan_en ##1
    state == lfwk_pkg::ST_EVAL);
  c_pattern_match: cover property (state == lfwk_pkg::ST_PATTERN && match);
  c_artificial: cover property ($rose(pulse_cnt != 13'h0000));
endmodule
`default_nettype wire

/* File: core/lfwk_pkg.sv */
// Package of constants and types for the wakeup mode controller
`default_nettype none
package lfwk_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned MCLK_HZ         = 40_000_000;
  localparam int unsigned SLOT_TIME_MS    = 1;
  localparam int unsigned SLOT_CYCLES     = MCLK_HZ / 1000 * SLOT_TIME_MS;
  localparam int unsigned WAKE_PULSE_NS   = 128_000;
  localparam int unsigned MCLK_PERIOD_NS  = 1_000_000_000 / MCLK_HZ;
  localparam int unsigned WAKE_PULSE_CYC  = WAKE_PULSE_NS / MCLK_PERIOD_NS;
  localparam int unsigned RTC_TICKS_PER_S = 32768;
  localparam int unsigned TOUT_STEP_MS    = 50;
  localparam int unsigned PREAMBLE_EDGES  = 8;
  localparam int unsigned PATTERN_SLACK   = 8;
  // ==========================================================
  // Register indices
  localparam logic [5:0] REG_CHAN_PWR   = 6'h00;
  localparam logic [5:0] REG_RX_FEAT    = 6'h01;
  localparam logic [5:0] REG_DUTY_GAIN  = 6'h04;
  localparam logic [5:0] REG_PAT_SECOND = 6'h05;
  localparam logic [5:0] REG_PAT_FIRST  = 6'h06;
  localparam logic [5:0] REG_TOUT_RATE  = 6'h07;
  localparam logic [5:0] REG_PERIODIC   = 6'h08;
  localparam logic [5:0] REG_RESERVED   = 6'h09;
  localparam logic [5:0] REG_STR_ONE    = 6'h0A;
  localparam logic [5:0] REG_STR_THREE  = 6'h0B;
  localparam logic [5:0] REG_STR_TWO    = 6'h0C;
  localparam logic [5:0] REG_FALSE_CNT  = 6'h0D;
  localparam int unsigned NUM_CFG       = 9;
  // Reset values of the writable registers, index 0 to 8
  localparam logic [NUM_CFG-1:0][7:0] CFG_RESET = {
    8'h00, 8'h0B, 8'h96, 8'h69, 8'h10, 8'h20, 8'h00, 8'h23, 8'h0E};
  // ==========================================================
  // Field positions
  localparam int unsigned BIT_ON_OFF    = 5;
  localparam int unsigned BIT_SCAN      = 4;
  localparam int unsigned BIT_EN_TWO    = 3;
  localparam int unsigned BIT_EN_THREE  = 2;
  localparam int unsigned BIT_EN_ONE    = 1;
  localparam int unsigned BIT_PWD       = 0;
  localparam int unsigned BIT_BIPHASE   = 3;
  localparam int unsigned BIT_DOUBLE    = 2;
  localparam int unsigned BIT_CORR      = 1;
  localparam int unsigned POS_T_OFF     = 6;
  localparam int unsigned POS_T_OUT     = 5;
  localparam int unsigned POS_T_AUTO    = 0;
  // Artificial wakeup windows in seconds, code 0 means off
  localparam logic [7:0][12:0] AUTO_SECONDS = {
    13'h1C20, 13'h0E10, 13'h0384, 13'h0078, 13'h0014, 13'h0005, 13'h0001, 13'h0000};
  // ==========================================================
  // Serial frame: mode, address, data
  localparam logic [1:0] SPI_WRITE  = 2'h0;
  localparam logic [1:0] SPI_READ   = 2'h1;
  localparam logic [1:0] SPI_CMD    = 2'h3;
  localparam logic [5:0] CMD_CLEAR_WAKE = 6'h00;
  typedef struct packed {
    logic [1:0] mode;
    logic [5:0] addr;
    logic [7:0] data;
  } lfwk_frame_s;
  typedef enum logic [2:0] {
    ST_PWD      = 3'h0,
    ST_LISTEN   = 3'h1,
    ST_EVAL     = 3'h2,
    ST_PREAMBLE = 3'h3,
    ST_PATTERN  = 3'h4,
    ST_RECEIVE  = 3'h5
  } lfwk_state_e;
endpackage
`default_nettype wire

/* File: testbench/lfwk_host_model.sv */
// Host microcontroller model driving serial frames into the controller
`default_nettype none
module lfwk_host_model (
  // Clock
  input  wire logic mclk,
  // Serial port
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // ==========================================================
  // Whole frame only; rx holds output enable at bit nine and the read byte
  // Half period of four clocks keeps margin over the three-flop sampler
  task automatic frame(input logic [15:0] tx, output logic [8:0] rx);
    rx = '0;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = tx[i];
      tk(4);
      spi_sclk = 1'b1;
      if (i == 7) rx[8] = spi_sdo_oe;
      if (i < 8) rx[7:0] = {rx[6:0], spi_sdo};
      tk(4);
      spi_sclk = 1'b0;
    end
    tk(4);
    spi_cs_n = 1'b1;
    // Released line shows the inverse so a stale bit is never reused
    spi_sdi = ~spi_sdi;
    tk(6);
  endtask
  task automatic clear_wake();
    logic [8:0] r;
    frame(16'hC000, r);
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_lf_wakeup_mode_controller.sv */
// Self-checking bench of the wakeup mode controller
`default_nettype none
module test_lf_wakeup_mode_controller;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals
  localparam int unsigned SLOT = 40;
  localparam int unsigned PULSE = 16;
  // Half-bit of eleven RTC ticks at eight clocks each
  localparam int unsigned HALF = 88;
  localparam logic [7:0] DEF [9] = '{8'h0E, 8'h23, 8'h00, 8'h20, 8'h10, 8'h69, 8'h96,
                                     8'h0B, 8'h00};
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       rtc_clk = 1'b0;
  logic       spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [2:0] carrier_det = 3'b000;
  logic       envelope = 1'b0;
  logic [4:0] strength_ch_one = 5'h00, strength_ch_two = 5'h00, strength_ch_three = 5'h00;
  logic [2:0] amp_on, mon;
  logic [1:0] demod_sel;
  logic       correlator_on, rtc_run, wake_out, demod_bitstream_pin, recovered_bitclock_pin;
  logic       mon_sel = 1'b0;
  int         err_count = 0;
  int         cmp_count = 0;
  always #12.5 mclk = ~mclk;
  always #100 rtc_clk = ~rtc_clk;
  assign mon = mon_sel ? {2'b00, wake_out} : amp_on;
  lfwk_mode_ctrl #(.SLOT_CYC(SLOT), .PULSE_CYC(PULSE), .RTC_PER_S(4)) u_dut (
    .mclk, .reset, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe, .rtc_clk,
    .carrier_det, .envelope, .strength_ch_one, .strength_ch_two, .strength_ch_three,
    .amp_on, .demod_sel, .correlator_on, .rtc_run, .wake_out, .demod_bitstream_pin,
    .recovered_bitclock_pin);
  lfwk_host_model u_host (.mclk, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe);
  // ==========================================================
  // Tasks
  task automatic tk(input int n = 1);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic bound(input int n, input int lim, input string m);
    if (n >= lim) begin
      err_count++;
      $display("[FAIL] %0t %s: wait ran out", $time, m);
      results();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [8:0] r;
    u_host.frame({2'b00, a, d}, r);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string m);
    logic [8:0] r;
    u_host.frame({2'b01, a, 8'h00}, r);
    chk(r, {1'b1, e}, m);
  endtask
  // Optional sync to a fresh start of v, then length of the run of v on mon
  task automatic span(input logic [2:0] v, input int len, input bit sy, input string m);
    int n;
    for (n = 0; sy && n < 500 && mon === v; n++) tk();
    for (n = 0; sy && n < 500 && mon !== v; n++) tk();
    bound(n, 500, m);
    chk(mon, v, m);
    for (n = 0; n < 500 && mon === v; n++) tk();
    chk(n, len, m);
  endtask
  // Preamble of nine edges a half-bit apart, then nb Manchester bits of w, MSB first
  task automatic send(input int nb, input logic [15:0] w);
    for (int i = 0; i < 9; i++) begin
      envelope = ~envelope;
      tk(HALF);
    end
    for (int i = 15; i > 15 - nb; i--) begin
      if (envelope == w[i]) envelope = ~envelope;
      tk(HALF);
      envelope = w[i];
      tk(HALF);
    end
  endtask
  initial begin
    #2_500_000;
    err_count++;
    $display("[FAIL] %0t run limit reached", $time);
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    int n;
    tk(10);
    reset = 1'b0;
    tk(6);
    chk(amp_on, 3'b111, "standard listen");
    chk(rtc_run, 1'b1, "rtc in listen");
    for (int i = 0; i < 9; i++) rd(6'(i), DEF[i], "reset value");
    wr(6'h09, 8'hFF);
    rd(6'h09, 8'h00, "reserved");
    rd(6'h20, 8'h00, "unmapped");
    wr(6'h04, 8'h5A);
    rd(6'h04, 8'h5A, "read back");
    wr(6'h04, 8'h10);
    $display("%0t registers done", $time);
    wr(6'h00, 8'h0F);
    tk(2);
    chk({amp_on, rtc_run, correlator_on, wake_out}, 6'h00, "power down");
    wr(6'h00, 8'h1E);
    span(3'b001, SLOT, 1, "scan one");
    span(3'b100, SLOT, 0, "scan three");
    span(3'b010, SLOT, 0, "scan two");
    chk(amp_on, 3'b001, "scan wrap");
    wr(6'h00, 8'h1A);
    span(3'b001, SLOT, 1, "pair one");
    span(3'b010, SLOT, 0, "pair two");
    $display("%0t scanning done", $time);
    wr(6'h00, 8'h1E);
    {strength_ch_one, strength_ch_two, strength_ch_three} = {5'h05, 5'h14, 5'h0C};
    carrier_det = 3'b111;
    tk(4);
    chk(amp_on, 3'b111, "carrier joins all");
    for (n = 0; n < 100 && correlator_on !== 1'b1; n++) tk();
    bound(n, 100, "preamble entry");
    chk(demod_sel, 2'd1, "strongest routed");
    send(0, 16'h0000);
    carrier_det = 3'b000;
    for (n = 0; n < 200 && correlator_on !== 1'b0; n++) tk();
    bound(n, 200, "correlation end");
    chk(wake_out, 1'b0, "no wake on fail");
    rd(6'h0D, 8'h01, "false count");
    rd(6'h0A, 8'h05, "strength one");
    rd(6'h0B, 8'h0C, "strength three");
    rd(6'h0C, 8'h14, "strength two");
    wr(6'h01, 8'h2B);
    wr(6'h00, 8'h0E);
    carrier_det = 3'b111;
    for (n = 0; n < 100 && correlator_on !== 1'b1; n++) tk();
    bound(n, 100, "second preamble");
    send(16, 16'h9669);
    for (n = 0; n < 200 && wake_out !== 1'b1; n++) tk();
    bound(n, 200, "pattern wake");
    chk(recovered_bitclock_pin, 1'b1, "clock shown");
    carrier_det = 3'b000;
    u_host.clear_wake();
    chk(wake_out, 1'b0, "wake dropped");
    chk(amp_on, 3'b111, "listening again");
    $display("%0t correlation done", $time);
    wr(6'h01, 8'h21);
    wr(6'h07, 8'h2B);
    carrier_det = 3'b001;
    envelope = 1'b1;
    for (n = 0; n < 200 && wake_out !== 1'b1; n++) tk();
    bound(n, 200, "bypass wake");
    chk(correlator_on, 1'b0, "correlator skipped");
    tk(4);
    chk(demod_bitstream_pin, 1'b1, "data high");
    envelope = 1'b0;
    tk(4);
    chk(demod_bitstream_pin, 1'b0, "data low");
    chk(recovered_bitclock_pin, 1'b0, "no clock");
    carrier_det = 3'b000;
    for (n = 0; n < 2100 && wake_out !== 1'b0; n++) tk();
    bound(n, 2100, "timeout return");
    chk(n >= 1940 && n <= 2010, 1'b1, "timeout length");
    chk(amp_on, 3'b111, "listening after timeout");
    $display("%0t receiving done", $time);
    wr(6'h00, 8'h2E);
    span(3'b111, SLOT, 1, "on slot");
    span(3'b000, SLOT, 0, "off slot");
    wr(6'h04, 8'h50);
    span(3'b000, 2 * SLOT, 1, "off two slots");
    wr(6'h00, 8'h0E);
    $display("%0t on off done", $time);
    mon_sel = 1'b1;
    wr(6'h08, 8'h01);
    span(3'b001, PULSE, 1, "artificial pulse");
    wr(6'h08, 8'h00);
    $display("%0t artificial wakeup done", $time);
    results();
  end
endmodule
`default_nettype wire
